// ### src/dtf_framer.sv
// downstream transport framer: mac bytes into 188-byte packets, apb control
// Function
// - unbroken 188-byte packets, header plus payload
// - every packet opens with 0x47
// - transport error bit sent as zero
// - start flag set means byte five is pointer
// - transport priority bit sent as zero
// - data packets carry identifier 0x1ffe
// - scrambling control sent as 00
// - adaptation control 01, never adaptation field
// - 4-bit continuity counter wraps per data packet
// - payload 183 with pointer, 184 without
// - gaps between frames filled with 0xff
// - frame control byte never 0xff; a 0xff one is still sent, only flagged in status
// - pointer counts bytes to skip before search
// - pointer present wherever a frame may start
// - other services may interleave at discretion
// - timestamps from 10.24 mhz timebase, output-referenced
// - timestamp differences taken modulo counter width
// - null packets instead of all-stuffing data packets
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dtf_framer
  import dtf_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  // mac byte stream
  input  wire logic          i_mac_valid,
  input  wire dtf_mac_byte_t i_mac,
  output logic               o_mac_ready,
  // transport byte stream to the modulator
  output logic               o_ts_valid,
  output logic [7:0]         o_ts_data,
  output logic               o_ts_sop,
  input  wire logic          i_ts_ready,
  // apb slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr
);

  // wrap-safe elapsed ticks between two timestamps
  function automatic logic [TB_W-1:0] ts_diff(input logic [TB_W-1:0] a,
                                              input logic [TB_W-1:0] b);
    ts_diff = a - b;
  endfunction

  // ---------------- timebase ----------------
  logic [11:0]     tb_acc;
  logic [11:0]     next_tb_acc;
  logic [TB_W-1:0] tbase;
  logic [TB_W-1:0] next_tbase;

  // fractional divider: 128 ticks every 3125 core cycles
  always_comb begin
    next_tb_acc = tb_acc + TB_INC;
    next_tbase  = tbase;
    if (next_tb_acc >= TB_MOD) begin
      next_tb_acc = next_tb_acc - TB_MOD;
      next_tbase  = tbase + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tb_acc <= 12'h0;
      tbase  <= 32'h0;
    end else begin
      tb_acc <= next_tb_acc;
      tbase  <= next_tbase;
    end
  end

  // ---------------- framer ----------------
  dtf_phase_t      phase;
  dtf_phase_t      next_phase;
  logic [7:0]      pos;
  logic [7:0]      next_pos;
  logic            is_data;
  logic            next_is_data;
  logic            pusi;
  logic            next_pusi;
  logic [3:0]      cc;
  logic [3:0]      next_cc;
  logic [3:0]      pkt_cc;
  logic [3:0]      next_pkt_cc;
  logic [15:0]     rem;
  logic [15:0]     next_rem;
  logic [1:0]      ts_idx;
  logic [1:0]      next_ts_idx;
  logic [TB_W-1:0] ts_val;
  logic [TB_W-1:0] next_ts_val;
  logic [TB_W-1:0] last_ts;
  logic [TB_W-1:0] next_last_ts;
  logic [TB_W-1:0] ts_gap;
  logic [TB_W-1:0] next_ts_gap;
  logic [31:0]     pkt_cnt;
  logic [31:0]     next_pkt_cnt;
  logic            vld;
  logic            next_vld;
  logic [7:0]      obyte;
  logic [7:0]      next_obyte;
  logic            osop;
  logic            next_osop;
  logic            adv;
  logic            take;
  logic            ev_badfc;
  logic            ev_under;
  logic            ctrl_en;
  logic [7:0]      mbyte;

  // output register advances whenever the modulator takes a byte
  assign adv         = !vld || i_ts_ready;
  assign o_mac_ready = take;
  assign o_ts_valid  = vld;
  assign o_ts_data   = obyte;
  assign o_ts_sop    = osop;

  always_comb begin
    next_phase   = phase;
    next_pos     = pos;
    next_is_data = is_data;
    next_pusi    = pusi;
    next_cc      = cc;
    next_pkt_cc  = pkt_cc;
    next_rem     = rem;
    next_ts_idx  = ts_idx;
    next_ts_val  = ts_val;
    next_last_ts = last_ts;
    next_ts_gap  = ts_gap;
    next_pkt_cnt = pkt_cnt;
    next_vld     = vld;
    next_obyte   = obyte;
    next_osop    = osop;
    take         = 1'b0;
    ev_badfc     = 1'b0;
    ev_under     = 1'b0;
    mbyte        = i_mac.data;
    // timestamp bytes replaced by the counter as they leave, so modulator delay is not counted
    if (ts_idx != 2'd0) begin
      mbyte = ts_val[8'(31 - 8 * int'(ts_idx)) -: 8];
    end else if (i_mac.ts) begin
      mbyte = tbase[31:24];
    end
    if (adv) begin
      next_vld  = 1'b1;
      next_osop = (pos == 8'd0);
      next_pos  = (pos == 8'(PKT_LEN - 1)) ? 8'd0 : pos + 8'd1;
      unique case (phase)
        PH_HDR: begin
          unique case (pos[1:0])
            2'd0: begin
              // data packet only when bytes exist; idle time goes out as null packets
              next_is_data = (rem != 16'd0) || (ctrl_en && i_mac_valid);
              // pointer whenever the tail leaves room for a new frame
              next_pusi    = next_is_data && (rem < 16'(PAY_LEN));
              next_pkt_cc  = cc;
              if (next_is_data) begin
                next_cc      = cc + 4'd1;
                next_pkt_cnt = pkt_cnt + 32'd1;
              end
              next_obyte = SYNC_BYTE;
            end
            2'd1: next_obyte = {TEI_TX, pusi, TPRI_TX,
                                is_data ? PID_DATA[12:8] : PID_NULL[12:8]};
            2'd2: next_obyte = is_data ? PID_DATA[7:0] : PID_NULL[7:0];
            2'd3: begin
              next_obyte = {SCR_CTRL, AF_CTRL, is_data ? pkt_cc : 4'h0};
              next_phase = pusi ? PH_PTR : PH_PAY;
            end
            default: next_obyte = STUFF_BYTE;
          endcase
        end
        PH_PTR: begin
          // skip count equals the tail still owed from the previous frame
          next_obyte = rem[7:0];
          next_phase = PH_PAY;
        end
        PH_PAY: begin
          next_obyte = STUFF_BYTE;
          if (is_data) begin
            if (rem != 16'd0) begin
              take = i_mac_valid;
              if (i_mac_valid) begin
                next_obyte = mbyte;
                next_rem   = rem - 16'd1;
              end else begin
                ev_under = 1'b1; // mid-frame starvation, stuffing leaks in
              end
            end else if (i_mac_valid && ctrl_en && pusi) begin
              take = 1'b1;
              if (i_mac.sof) begin
                next_obyte = mbyte;
                next_rem   = (i_mac.len == 16'd0) ? 16'd0 : i_mac.len - 16'd1;
                ev_badfc   = (i_mac.data == STUFF_BYTE);
              end else begin
                ev_under = 1'b1; // stray byte outside a frame is dropped
              end
            end
            if (take && i_mac_valid && (ts_idx != 2'd0 || i_mac.ts)) begin
              next_ts_idx = ts_idx + 2'd1;
              if (ts_idx == 2'd0) begin
                next_ts_val  = tbase;
                next_last_ts = tbase;
                next_ts_gap  = ts_diff(tbase, last_ts);
              end
            end
          end
          if (pos == 8'(PKT_LEN - 1)) begin
            next_phase = PH_HDR;
          end
        end
        default: next_phase = PH_HDR;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase   <= PH_HDR;
      pos     <= 8'd0;
      is_data <= 1'b0;
      pusi    <= 1'b0;
      cc      <= 4'h0;
      pkt_cc  <= 4'h0;
      rem     <= 16'd0;
      ts_idx  <= 2'd0;
      ts_val  <= 32'h0;
      last_ts <= 32'h0;
      ts_gap  <= 32'h0;
      pkt_cnt <= 32'h0;
      vld     <= 1'b0;
      obyte   <= 8'h0;
      osop    <= 1'b0;
    end else begin
      phase   <= next_phase;
      pos     <= next_pos;
      is_data <= next_is_data;
      pusi    <= next_pusi;
      cc      <= next_cc;
      pkt_cc  <= next_pkt_cc;
      rem     <= next_rem;
      ts_idx  <= next_ts_idx;
      ts_val  <= next_ts_val;
      last_ts <= next_last_ts;
      ts_gap  <= next_ts_gap;
      pkt_cnt <= next_pkt_cnt;
      vld     <= next_vld;
      obyte   <= next_obyte;
      osop    <= next_osop;
    end
  end

  // ---------------- apb registers ----------------
  logic        badfc;
  logic        next_badfc;
  logic        under;
  logic        next_under;
  logic        next_ctrl_en;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        rerr;
  logic        next_rerr;
  logic        setup;
  logic        wr;
  logic        hit;

  // data latched in the setup cycle so the access phase answers at once
  assign setup     = i_psel && !i_penable;
  assign wr        = i_psel && i_penable && i_pwrite;
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = o_pready && rerr;
  assign o_prdata  = rdata;

  always_comb begin
    next_ctrl_en = ctrl_en;
    next_rdata   = rdata;
    next_rerr    = rerr;
    hit          = (i_paddr == REG_CTRL) || (i_paddr == REG_STATUS) ||
                   (i_paddr == REG_TBASE) || (i_paddr == REG_TS_GAP) ||
                   (i_paddr == REG_PKT_CNT);
    // write one to clear; a new event in the same cycle still wins
    next_badfc   = ev_badfc || (badfc && !(wr && i_paddr == REG_STATUS &&
                                           i_pwdata[ST_BADFC_BIT]));
    next_under   = ev_under || (under && !(wr && i_paddr == REG_STATUS &&
                                           i_pwdata[ST_UNDER_BIT]));
    if (wr && i_paddr == REG_CTRL) begin
      next_ctrl_en = i_pwdata[CTRL_EN_BIT];
    end
    if (setup) begin
      next_rerr  = !hit;
      next_rdata = 32'h0;
      if (!i_pwrite) begin
        unique case (i_paddr)
          REG_CTRL:    next_rdata[CTRL_EN_BIT] = ctrl_en;
          REG_STATUS: begin
            next_rdata[ST_BADFC_BIT]           = badfc;
            next_rdata[ST_UNDER_BIT]           = under;
            next_rdata[ST_CC_LSB +: 4]         = cc;
            next_rdata[ST_BUSY_BIT]            = (rem != 16'd0);
          end
          REG_TBASE:   next_rdata = tbase;
          REG_TS_GAP:  next_rdata = ts_gap;
          REG_PKT_CNT: next_rdata = pkt_cnt;
          default:     next_rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_en <= CTRL_EN_RST;
      badfc   <= 1'b0;
      under   <= 1'b0;
      rdata   <= 32'h0;
      rerr    <= 1'b0;
    end else begin
      ctrl_en <= next_ctrl_en;
      badfc   <= next_badfc;
      under   <= next_under;
      rdata   <= next_rdata;
      rerr    <= next_rerr;
    end
  end

endmodule
`default_nettype wire

// ### src/dtf_pkg.sv
// constants and carrier types for the downstream transport framer
package dtf_pkg;
  // transport packet geometry
  localparam int          PKT_LEN     = 188;
  localparam int          HDR_LEN     = 4;
  localparam int          PAY_LEN     = 184;
  localparam int          PAY_PTR_LEN = 183;
  // header field values
  localparam logic [7:0]  SYNC_BYTE   = 8'h47;
  localparam logic        TEI_TX      = 1'b0;
  localparam logic        TPRI_TX     = 1'b0;
  localparam logic [12:0] PID_DATA    = 13'h1ffe;
  localparam logic [12:0] PID_NULL    = 13'h1fff;
  localparam logic [1:0]  SCR_CTRL    = 2'b00;
  localparam logic [1:0]  AF_CTRL     = 2'b01;
  localparam logic [7:0]  STUFF_BYTE  = 8'hff;
  // timebase: fractional divider from the core clock
  localparam longint      CLK_HZ      = 250_000_000;
  localparam longint      TB_HZ       = 10_240_000;
  localparam longint      TB_GCD      = 80_000;
  localparam logic [11:0] TB_INC      = 12'(TB_HZ / TB_GCD);
  localparam logic [11:0] TB_MOD      = 12'(CLK_HZ / TB_GCD);
  localparam int          TB_W        = 32;
  // apb register byte offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_TBASE   = 8'h08;
  localparam logic [7:0]  REG_TS_GAP  = 8'h0c;
  localparam logic [7:0]  REG_PKT_CNT = 8'h10;
  // field positions
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          ST_BADFC_BIT = 0;
  localparam int          ST_UNDER_BIT = 1;
  localparam int          ST_CC_LSB    = 8;
  localparam int          ST_BUSY_BIT  = 16;
  localparam logic        CTRL_EN_RST  = 1'b0;

  // one byte offered by the mac layer
  typedef struct packed {
    logic        sof;
    logic        ts;
    logic [15:0] len;
    logic [7:0]  data;
  } dtf_mac_byte_t;

  typedef enum logic [1:0] {PH_HDR, PH_PTR, PH_PAY} dtf_phase_t;
endpackage

// ### tb/dtf_framer_checker.sv
// port assertions for the transport framer
`timescale 1ns/1ns
`default_nettype none
module dtf_framer_checker
  import dtf_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       o_ts_valid,
  input wire logic [7:0] o_ts_data,
  input wire logic       o_ts_sop,
  input wire logic       i_ts_ready,
  input wire logic       o_mac_ready,
  input wire logic       o_pready,
  input wire logic       o_pslverr
);
  logic [7:0] idx, next_idx, pid_lo, next_pid_lo;
  logic [3:0] cc, next_cc;
  logic       have_cc, next_have_cc;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // byte position, identifier and counter as seen on the wire
  always_comb begin
    next_idx = idx;
    next_pid_lo = pid_lo;
    next_cc = cc;
    next_have_cc = have_cc;
    if (o_ts_valid && i_ts_ready) begin
      next_idx = (idx == 8'hbb) ? 8'h00 : idx + 8'h01;
      if (idx == 8'h02) next_pid_lo = o_ts_data;
      if (idx == 8'h03 && pid_lo == 8'hfe) begin
        next_cc = o_ts_data[3:0];
        next_have_cc = 1'b1;
      end
    end
  end
  // registers restart with the design so positions stay aligned
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      idx <= 8'h00;
      pid_lo <= 8'h00;
      cc <= 4'h0;
      have_cc <= 1'b0;
    end else begin
      idx <= next_idx;
      pid_lo <= next_pid_lo;
      cc <= next_cc;
      have_cc <= next_have_cc;
    end
  end
  chk_sync_value: assert property (o_ts_sop |-> o_ts_data == SYNC_BYTE)
    else $error("packet start byte is not sync");
  chk_sop_place: assert property (o_ts_valid |-> o_ts_sop == (idx == 8'h00))
    else $error("packet start flag off the 188 byte grid");
  chk_flag_bits: assert property (o_ts_valid && idx == 8'h01 |-> !o_ts_data[7] && !o_ts_data[5])
    else $error("error or priority bit set");
  chk_pid_high: assert property (o_ts_valid && idx == 8'h01 |-> o_ts_data[4:0] == 5'h1f)
    else $error("identifier high bits wrong");
  chk_ctrl_bits: assert property (o_ts_valid && idx == 8'h03 |-> o_ts_data[7:4] == 4'h1)
    else $error("scrambling or adaptation control wrong");
  chk_cc_step: assert property (o_ts_valid && idx == 8'h03 && pid_lo == 8'hfe && have_cc
    |-> o_ts_data[3:0] == cc + 4'h1)
    else $error("continuity counter did not step");
  chk_null_stuff: assert property (o_ts_valid && idx > 8'h03 && pid_lo == 8'hff
    |-> o_ts_data == STUFF_BYTE)
    else $error("null packet payload not stuffing");
  chk_hold_stall: assert property (o_ts_valid && !i_ts_ready |=> o_ts_valid && $stable(o_ts_data))
    else $error("byte changed while stalled");
  // byte 4 is produced while byte 3 leaves, so a pointerless packet takes mac data at idx 3
  chk_mac_gap: assert property (o_mac_ready |-> o_ts_valid && i_ts_ready && idx > 8'h02)
    else $error("mac byte taken in header");
  chk_err_resp: assert property (o_pslverr |-> o_pready)
    else $error("error response outside access");
endmodule
bind dtf_framer dtf_framer_checker i_chk (.i_core_clk, .i_rst, .o_ts_valid, .o_ts_data,
  .o_ts_sop, .i_ts_ready, .o_mac_ready, .o_pready, .o_pslverr);
`default_nettype wire

// ### tb/dtf_mod_model.sv
// modulator stand-in: takes transport bytes, may stall, keeps the last packet
`timescale 1ns/1ns
`default_nettype none
module dtf_mod_model
  import dtf_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slow,
  input  wire logic       i_ts_valid,
  input  wire logic [7:0] i_ts_data,
  output logic            o_ts_ready,
  output logic            o_done,
  output logic            o_is_data
);
  logic [7:0] pkt [0:187];
  logic [7:0] pos;
  logic [1:0] div;
  logic [3:0] good;
  logic [3:0] bad;
  logic       locked;
  // slow mode takes one byte in three, so the framer must hold its output
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pos <= 8'h00;
      div <= 2'h0;
      o_ts_ready <= 1'b0;
      o_done <= 1'b0;
      good <= 4'h0;
      bad <= 4'h0;
      locked <= 1'b0;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      o_ts_ready <= !i_slow || div == 2'h2;
      o_done <= 1'b0;
      if (i_ts_valid && o_ts_ready) begin
        pkt[pos] <= i_ts_data;
        pos <= (pos == 8'hbb) ? 8'h00 : pos + 8'h01;
        o_done <= pos == 8'hbb;
        // sync at the packet boundary stands in for the line parity check
        if (pos == 8'h00 && i_ts_data == SYNC_BYTE) begin
          good <= (good == 4'h5) ? good : good + 4'h1;
          bad <= 4'h0;
          locked <= locked || good == 4'h4;
        end else if (pos == 8'h00) begin
          bad <= (bad == 4'h9) ? bad : bad + 4'h1;
          good <= 4'h0;
          locked <= locked && bad != 4'h8;
        end
      end
    end
  end
  // foreign identifiers are not treated as mac data
  assign o_is_data = {pkt[1][4:0], pkt[2]} == PID_DATA;
endmodule
`default_nettype wire

// ### tb/tb.sv
// testbench for the transport framer
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dtf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, mac_valid = 1'b0, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, t1;
  dtf_mac_byte_t mac = '0;
  wire logic mac_ready, ts_valid, ts_ready, done, is_data, pready, pslverr;
  wire logic [7:0] ts_data;
  wire logic [31:0] prdata;
  logic [7:0] pk [0:187];
  int error_cnt = 0, compares = 0;
  always #2 clk = ~clk;
  dtf_framer i_dut (.i_core_clk(clk), .i_rst(rst), .i_mac_valid(mac_valid), .i_mac(mac),
    .o_mac_ready(mac_ready), .o_ts_valid(ts_valid), .o_ts_data(ts_data), .o_ts_sop(),
    .i_ts_ready(ts_ready), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  dtf_mod_model i_mod (.i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_ts_valid(ts_valid),
    .i_ts_data(ts_data), .o_ts_ready(ts_ready), .o_done(done), .o_is_data(is_data));
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic timed_out();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  function automatic logic [7:0] fd(input int i);
    return 8'(i) & 8'h7f;
  endfunction
  // one apb transfer, called just after a rising edge; answer taken at the edge with pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // offers a frame byte by byte, each held until taken; ts_at marks a timestamp, -1 none
  task automatic send_frame(input int len, input logic [7:0] fc, input int ts_at);
    int n;
    for (int i = 0; i < len; i++) begin
      mac_valid <= 1'b1;
      mac <= '{sof: i == 0, ts: i == ts_at, len: 16'(len), data: (i == 0) ? fc : fd(i)};
      n = 0;
      do begin @(negedge clk); n++; end while (mac_ready !== 1'b1 && n < 2000);
      if (mac_ready !== 1'b1) timed_out();
      @(posedge clk);
    end
    mac_valid <= 1'b0;
  endtask
  task automatic get_pkt();
    int n = 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 2000);
    if (done !== 1'b1) timed_out();
    for (int i = 0; i < 188; i++) pk[i] = i_mod.pkt[i];
  endtask
  // header, pointer and payload of a data packet; frame byte zero is 0xc2
  task automatic chk_pkt(input int first, input int cnt, input logic pusi, input int ptr,
                         input logic [3:0] cc);
    int s = pusi ? 5 : 4;
    check(pk[0], SYNC_BYTE, "sync");
    check({pk[1], pk[2]}, {3'b000, PID_DATA} | {1'b0, pusi, 14'h0}, "pid and start flag");
    check(pk[3], {SCR_CTRL, AF_CTRL, cc}, "control and counter");
    if (pusi) check(pk[4], 8'(ptr), "pointer");
    for (int k = 0; k < 188 - s; k++)
      check(pk[s + k], (k >= cnt) ? STUFF_BYTE : (first + k == 0) ? 8'hc2 : fd(first + k), "payload");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset value");
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0, "unmapped read data");
    check({31'h0, err}, 32'h1, "unmapped read error");
    apb(1'b0, REG_TBASE, 32'h0);
    t1 = rd;
    repeat (2497) @(posedge clk);
    apb(1'b0, REG_TBASE, 32'h0);
    check(32'((rd - t1) inside {[101:104]}), 32'h1, "timebase rate");
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h1, "ctrl enable");
    slow <= 1'b1;
    fork
      send_frame(400, 8'hc2, -1);
      begin
        for (int t = 0; t < 5 && is_data !== 1'b1; t++) get_pkt();
        chk_pkt(0, 183, 1'b1, 0, 4'h0);
        get_pkt();
        chk_pkt(183, 184, 1'b0, 0, 4'h1);
        get_pkt();
        chk_pkt(367, 33, 1'b1, 33, 4'h2);
        get_pkt();
        check(pk[2], PID_NULL[7:0], "null after frame");
      end
    join
    check({31'h0, i_mod.locked}, 32'h1, "receiver aligned");
    @(posedge clk);
    slow <= 1'b0;
    apb(1'b0, REG_PKT_CNT, 32'h0);
    check(rd, 32'h3, "data packet count");
    send_frame(4, STUFF_BYTE, -1);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[ST_BADFC_BIT], 1'b1, "bad frame control flagged");
    check({28'h0, rd[ST_CC_LSB +: 4]}, 32'h4, "next continuity counter");
    apb(1'b1, REG_STATUS, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[ST_BADFC_BIT], 1'b0, "flag cleared");
    // two stamped frames about 2500 cycles apart, plus up to one packet of waiting
    send_frame(6, 8'h44, 1);
    repeat (2497) @(posedge clk);
    send_frame(6, 8'h44, 1);
    apb(1'b0, REG_TS_GAP, 32'h0);
    check(32'(rd inside {[101:112]}), 32'h1, "timestamp gap");
    report_and_stop();
  end
endmodule
`default_nettype wire
